// ---- chp_pkg.sv ----
package chp_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 8;
	localparam int SETUP_NS = 30;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 20;
	// least times, rounded up to whole cycles
	localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);

	// ****************************************
	// widths and fields
	// ****************************************
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int DISK_ADDR_W = 3;
	localparam logic [7:0] DISK_ADDR_HI = 8'h00;
	localparam logic [15:0] DATA_ZERO = 16'h0000;

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [2:0] {
		ST_BOOT = 3'h0,
		ST_WAIT_RDY = 3'h1,
		ST_IDLE = 3'h2,
		ST_SETUP = 3'h3,
		ST_STROBE = 3'h4,
		ST_HOLD = 3'h5
	} chp_state_e_t;

	typedef enum logic [1:0] {
		MODE_MEM = 2'h0,
		MODE_IO = 2'h1,
		MODE_DISK = 2'h2
	} chp_mode_t;

	typedef enum logic [1:0] {
		KIND_MEM_RD = 2'h0,
		KIND_ATTR_RD = 2'h1,
		KIND_IO_RD = 2'h2,
		KIND_IO_WR = 2'h3
	} chp_kind_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		chp_kind_t kind;
		logic [10:0] addr;
		logic [15:0] wdata;
	} chp_cmd_t;

	typedef struct packed {
		logic [15:0] rdata;
		logic acked;
		logic from_dma;
	} chp_rsp_t;

	typedef struct packed {
		chp_state_e_t st;
		chp_mode_t mode;
		logic [7:0] cnt;
		chp_kind_t kind;
		logic is_dma;
		logic [10:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic acked;
		logic cmd_ready;
		logic rsp_valid;
		logic oe_n;
		logic reg_n;
		logic io_rd_n;
		logic io_wr_n;
		logic grant_n;
		logic data_oe;
		logic pullup_en;
	} chp_regs_t;

	localparam chp_regs_t RST_REGS = '{
		st: ST_BOOT, mode: MODE_MEM, cnt: 8'h00, kind: KIND_MEM_RD,
		is_dma: 1'b0, addr: 11'h000, wdata: 16'h0000, rdata: 16'h0000,
		acked: 1'b0, cmd_ready: 1'b0, rsp_valid: 1'b0, oe_n: 1'b1,
		reg_n: 1'b1, io_rd_n: 1'b1, io_wr_n: 1'b1, grant_n: 1'b1,
		data_oe: 1'b0, pullup_en: 1'b1
	};

endpackage

// ---- chp_sync.sv ----
`timescale 1ns/1ps

// ****************************************
// two flip-flop synchroniser for card pins
// ****************************************
module chp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] dout_ff;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= '0;
			dout_ff <= '0;
		end else begin
			meta_ff <= din;
			dout_ff <= meta_ff;
		end
	end

	assign dout = dout_ff;

endmodule

// ---- chp_host.sv ----
`timescale 1ns/1ps

module chp_host (
	input wire logic clk,
	input wire logic rstn,
	// user side
	input wire logic cfg_disk_mode,
	input wire logic cfg_io_mode,
	input wire logic cmd_valid,
	input wire chp_pkg::chp_cmd_t cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output chp_pkg::chp_rsp_t rsp,
	input wire logic dma_enable,
	input wire logic dma_dir_write,
	input wire logic dma_suspend,
	input wire logic [15:0] dma_wdata,
	// card pins
	output logic [10:0] card_addr,
	output logic card_reg_n,
	output logic card_oe_n,
	output logic io_read_strobe_n,
	output logic io_write_strobe_n,
	output logic dma_grant_n,
	output logic [15:0] card_data_out,
	output logic card_data_oe,
	output logic ready_pullup_en,
	input wire logic [15:0] card_data_in,
	input wire logic card_ack_request,
	input wire logic ready_not_busy
);

	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [17:0] pins_s;
	logic [15:0] data_s;
	logic ack_req_s;
	logic rdy_s;

	chp_sync #(.W(18)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.din({card_data_in, card_ack_request, ready_not_busy}),
		.dout(pins_s)
	);

	// split synchronised pins
	assign data_s = pins_s[17:2];
	assign ack_req_s = pins_s[1];
	assign rdy_s = pins_s[0];

	// ****************************************
	// controller state
	// ****************************************
	chp_pkg::chp_regs_t s;
	chp_pkg::chp_regs_t n;
	logic gate_ok;

	// next state of the whole controller
	always_comb begin
		n = s;
		n.rsp_valid = 1'b0;
		n.pullup_en = 1'b1;
		gate_ok = 1'b1;
		unique case (s.st)
			chp_pkg::ST_BOOT: begin
				// mode picked once after reset release
				if (cfg_disk_mode) begin
					n.mode = chp_pkg::MODE_DISK;
					n.oe_n = 1'b0;
					n.st = chp_pkg::ST_IDLE;
					n.cmd_ready = 1'b1;
				end else begin
					n.mode = cfg_io_mode ? chp_pkg::MODE_IO : chp_pkg::MODE_MEM;
					n.st = chp_pkg::ST_WAIT_RDY;
				end
			end
			chp_pkg::ST_WAIT_RDY: begin
				// hold off access after boot until the card first reports ready; disk mode skips this wait
				if (rdy_s) begin
					n.st = chp_pkg::ST_IDLE;
					n.cmd_ready = 1'b1;
				end
			end
			chp_pkg::ST_IDLE: begin
				if (cmd_valid && s.cmd_ready) begin
					n.kind = cmd.kind;
					n.wdata = cmd.wdata;
					n.is_dma = 1'b0;
					n.cmd_ready = 1'b0;
					n.data_oe = (cmd.kind == chp_pkg::KIND_IO_WR);
					n.cnt = chp_pkg::SETUP_CYC - 8'h01;
					n.st = chp_pkg::ST_SETUP;
					if (s.mode == chp_pkg::MODE_DISK) begin
						// upper lines grounded in disk mode
						n.addr = {chp_pkg::DISK_ADDR_HI,
							cmd.addr[chp_pkg::DISK_ADDR_W-1:0]};
						n.reg_n = 1'b1;
					end else begin
						n.addr = cmd.addr;
						// common high, attribute and I/O low
						n.reg_n = (cmd.kind == chp_pkg::KIND_MEM_RD);
					end
				end else if (s.mode == chp_pkg::MODE_DISK && dma_enable &&
					ack_req_s && !dma_suspend && s.cmd_ready) begin
					// grant a word in answer to the request
					n.grant_n = 1'b0;
					n.is_dma = 1'b1;
					n.cmd_ready = 1'b0;
					n.kind = dma_dir_write ? chp_pkg::KIND_IO_WR :
						chp_pkg::KIND_IO_RD;
					n.wdata = dma_wdata;
					n.data_oe = dma_dir_write;
					n.cnt = chp_pkg::SETUP_CYC - 8'h01;
					n.st = chp_pkg::ST_SETUP;
				end
			end
			chp_pkg::ST_SETUP: begin
				if (s.cnt == 8'h00) begin
					n.acked = 1'b0;
					n.cnt = chp_pkg::STROBE_CYC - 8'h01;
					n.st = chp_pkg::ST_STROBE;
					unique case (s.kind)
						chp_pkg::KIND_IO_RD: n.io_rd_n = 1'b0;
						chp_pkg::KIND_IO_WR: n.io_wr_n = 1'b0;
						chp_pkg::KIND_MEM_RD, chp_pkg::KIND_ATTR_RD: n.oe_n = 1'b0;
					endcase
				end else begin
					n.cnt = s.cnt - 8'h01;
				end
			end
			chp_pkg::ST_STROBE: begin
				// ack low marks data the card is really answering with
				if (s.mode == chp_pkg::MODE_IO && !ack_req_s) begin
					n.acked = 1'b1;
				end
				gate_ok = (s.kind != chp_pkg::KIND_IO_RD) ||
					(s.mode != chp_pkg::MODE_IO) || s.acked || !ack_req_s;
				if (s.cnt == 8'h00) begin
					n.rdata = gate_ok ? data_s : chp_pkg::DATA_ZERO;
					n.acked = gate_ok;
					n.io_rd_n = 1'b1;
					n.io_wr_n = 1'b1; // rising edge latches write data
					n.oe_n = (s.mode == chp_pkg::MODE_DISK) ? 1'b0 : 1'b1;
					n.cnt = chp_pkg::HOLD_CYC - 8'h01;
					n.st = chp_pkg::ST_HOLD;
				end else begin
					n.cnt = s.cnt - 8'h01;
				end
			end
			chp_pkg::ST_HOLD: begin
				if (s.cnt == 8'h00) begin
					n.data_oe = 1'b0;
					n.grant_n = 1'b1;
					n.reg_n = 1'b1;
					n.rsp_valid = 1'b1;
					n.cmd_ready = 1'b1;
					n.st = chp_pkg::ST_IDLE;
				end else begin
					n.cnt = s.cnt - 8'h01;
				end
			end
			default: begin
				n = chp_pkg::RST_REGS;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= chp_pkg::RST_REGS;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign cmd_ready = s.cmd_ready;
	assign rsp_valid = s.rsp_valid;
	assign rsp = '{rdata: s.rdata, acked: s.acked, from_dma: s.is_dma};
	assign card_addr = s.addr;
	assign card_reg_n = s.reg_n;
	assign card_oe_n = s.oe_n;
	assign io_read_strobe_n = s.io_rd_n;
	assign io_write_strobe_n = s.io_wr_n;
	assign dma_grant_n = s.grant_n;
	assign card_data_out = s.wdata;
	assign card_data_oe = s.data_oe;
	assign ready_pullup_en = s.pullup_en;

	// ****************************************
	// checks
	// ****************************************
	chk_ack_gates_data: assert property (@(posedge clk) disable iff (!rstn)
		(s.rsp_valid && !s.acked) |-> (s.rdata == chp_pkg::DATA_ZERO))
		else $error("unacknowledged read data was passed on");

	chk_grant_after_req: assert property (@(posedge clk) disable iff (!rstn)
		$fell(s.grant_n) |-> $past(ack_req_s) && s.mode == chp_pkg::MODE_DISK)
		else $error("grant given without a request");

	chk_disk_oe_low: assert property (@(posedge clk) disable iff (!rstn)
		(s.st != chp_pkg::ST_BOOT && s.mode == chp_pkg::MODE_DISK) |-> !s.oe_n)
		else $error("read strobe pin not grounded in disk mode");

	chk_pullup_on: assert property (@(posedge clk) disable iff (!rstn)
		##1 s.pullup_en)
		else $error("ready line pull-up not enabled");

	chk_no_busy_access: assert property (@(posedge clk) disable iff (!rstn)
		(s.st == chp_pkg::ST_WAIT_RDY) |=>
		(s.st == chp_pkg::ST_WAIT_RDY || $past(rdy_s)) && s.io_rd_n &&
		s.io_wr_n && s.oe_n)
		else $error("access started while card busy");

	chk_reg_common_attr: assert property (@(posedge clk) disable iff (!rstn)
		(!s.oe_n && s.mode != chp_pkg::MODE_DISK) |->
		(s.reg_n == (s.kind == chp_pkg::KIND_MEM_RD)))
		else $error("attribute select wrong for memory read");

	chk_reg_io_low: assert property (@(posedge clk) disable iff (!rstn)
		((!s.io_rd_n || !s.io_wr_n) && s.mode != chp_pkg::MODE_DISK) |->
		!s.reg_n)
		else $error("attribute select high during I/O cycle");

	chk_suspend_grant: assert property (@(posedge clk) disable iff (!rstn)
		$fell(s.grant_n) |-> !$past(dma_suspend) ##[1:40] s.grant_n)
		else $error("grant given during suspend or held too long");

endmodule

// ---- chp_card_model.sv ----
`timescale 1ns/1ps

// ****************************************
// card model
// ****************************************
module chp_card_model #(
	parameter int BOOT_CYC = 20
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cfg_io_mode,
	input wire logic cfg_disk_mode,
	input wire logic card_event,
	input wire logic [3:0] dma_words,
	input wire logic dma_load,
	input wire logic [10:0] card_addr,
	input wire logic card_reg_n,
	input wire logic card_oe_n,
	input wire logic io_read_strobe_n,
	input wire logic io_write_strobe_n,
	input wire logic dma_grant_n,
	input wire logic [15:0] card_data_out,
	input wire logic card_data_oe,
	output logic [15:0] card_data_in,
	output logic card_ack_request,
	output logic ready_not_busy
);
	logic [15:0] wreg_ff, last_ff, val;
	logic [7:0] boot_ff;
	logic [3:0] left_ff;
	logic req_ff, gnt_ff, wr_strobe_ff, drv;
	logic io_rd;

	// answers I/O reads only in the lower half of the port space
	assign io_rd = cfg_io_mode & !io_read_strobe_n & !card_reg_n &
		!card_addr[10];

	// read data steering per mode
	always_comb begin
		drv = 1'b1;
		val = ~last_ff;
		if (cfg_disk_mode & !io_read_strobe_n) begin
			if (!dma_grant_n)
				val = 16'hD00D;
			else if (card_addr[2:0] == 3'h0)
				val = wreg_ff;
			else
				val = {13'h1C00, card_addr[2:0]};
		end else if (io_rd)
			val = wreg_ff ^ {5'h00, card_addr};
		else if (!cfg_disk_mode & !card_oe_n)
			val = {card_reg_n ? 4'hA : 4'h5, 1'b0, card_addr};
		else
			drv = 1'b0; // released bus shows inverse of last word
	end

	assign card_data_in = val;
	assign card_ack_request = cfg_disk_mode ? req_ff : !io_rd;
	// not busy in reset, busy until boot ends, then per mode
	assign ready_not_busy = !rstn ? 1'b1 :
		(boot_ff != 8'h00) ? 1'b0 :
		(cfg_disk_mode ? card_event : !card_event);

	// boot count, write capture, request handshake
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_ff <= 8'(BOOT_CYC);
			wreg_ff <= 16'h0000;
			last_ff <= 16'h0000;
			left_ff <= 4'h0;
			req_ff <= 1'b0;
			gnt_ff <= 1'b1;
			wr_strobe_ff <= 1'b1;
		end else begin
			if (boot_ff != 8'h00)
				boot_ff <= boot_ff - 8'h01;
			if (drv)
				last_ff <= val;
			wr_strobe_ff <= io_write_strobe_n;
			// capture only while the host really drives the bus
			if (io_write_strobe_n & !wr_strobe_ff & card_data_oe)
				wreg_ff <= card_data_out;
			gnt_ff <= dma_grant_n;
			if (dma_load)
				left_ff <= dma_words;
			else if (!dma_grant_n & gnt_ff)
				left_ff <= left_ff - 4'h1;
			req_ff <= dma_grant_n & (left_ff != 4'h0);
		end
	end
endmodule

// ---- tb_card_host_port_signals.sv ----
`timescale 1ns/1ps

// ****************************************
// testbench
// ****************************************
module tb_card_host_port_signals;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cfg_disk_mode = 1'b0;
	logic cfg_io_mode = 1'b0;
	logic cmd_valid = 1'b0;
	chp_pkg::chp_cmd_t cmd = '0;
	logic dma_enable = 1'b0;
	logic dma_dir_write = 1'b0;
	logic dma_suspend = 1'b0;
	logic [15:0] dma_wdata = 16'h0000;
	logic card_event = 1'b0;
	logic dma_load = 1'b0;
	logic [3:0] dma_words = 4'h0;
	logic cmd_ready, rsp_valid, card_reg_n, card_oe_n, io_read_strobe_n;
	logic io_write_strobe_n, dma_grant_n, card_data_oe, ready_pullup_en;
	logic card_ack_request, ready_not_busy;
	logic [10:0] card_addr;
	logic [15:0] card_data_out, card_data_in;
	chp_pkg::chp_rsp_t rsp, got;
	int mismatches = 0;
	int comparisons = 0;

	always #4 clk = ~clk;

	chp_host chp_host_i (
		.clk(clk),
		.rstn(rstn),
		.cfg_disk_mode(cfg_disk_mode),
		.cfg_io_mode(cfg_io_mode),
		.cmd_valid(cmd_valid),
		.cmd(cmd),
		.cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid),
		.rsp(rsp),
		.dma_enable(dma_enable),
		.dma_dir_write(dma_dir_write),
		.dma_suspend(dma_suspend),
		.dma_wdata(dma_wdata),
		.card_addr(card_addr),
		.card_reg_n(card_reg_n),
		.card_oe_n(card_oe_n),
		.io_read_strobe_n(io_read_strobe_n),
		.io_write_strobe_n(io_write_strobe_n),
		.dma_grant_n(dma_grant_n),
		.card_data_out(card_data_out),
		.card_data_oe(card_data_oe),
		.ready_pullup_en(ready_pullup_en),
		.card_data_in(card_data_in),
		.card_ack_request(card_ack_request),
		.ready_not_busy(ready_not_busy)
	);

	chp_card_model chp_card_model_i (
		.clk(clk),
		.rstn(rstn),
		.cfg_io_mode(cfg_io_mode),
		.cfg_disk_mode(cfg_disk_mode),
		.card_event(card_event),
		.dma_words(dma_words),
		.dma_load(dma_load),
		.card_addr(card_addr),
		.card_reg_n(card_reg_n),
		.card_oe_n(card_oe_n),
		.io_read_strobe_n(io_read_strobe_n),
		.io_write_strobe_n(io_write_strobe_n),
		.dma_grant_n(dma_grant_n),
		.card_data_out(card_data_out),
		.card_data_oe(card_data_oe),
		.card_data_in(card_data_in),
		.card_ack_request(card_ack_request),
		.ready_not_busy(ready_not_busy)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// bounded wait for ready or response high, seen at the falling edge
	task automatic wait_hi(input logic on_rsp);
		logic v;
		@(negedge clk);
		v = on_rsp ? rsp_valid : cmd_ready;
		for (int i = 0; i < 200 && v !== 1'b1; i++) begin
			@(negedge clk);
			v = on_rsp ? rsp_valid : cmd_ready;
		end
		if (v !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
	endtask

	task automatic boot(input logic io, input logic disk);
		@(posedge clk);
		rstn <= 1'b0;
		cfg_io_mode <= io;
		cfg_disk_mode <= disk;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
	endtask

	// one command, held until the take edge, response kept in got
	task automatic xfer(input chp_pkg::chp_kind_t k, input logic [10:0] a,
		input logic [15:0] d);
		wait_hi(1'b0);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{kind: k, addr: a, wdata: d};
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_hi(1'b1);
		got = rsp;
	endtask

	// memory mode: boot hold-off, common and attribute reads
	task automatic sc_memory();
		boot(1'b0, 1'b0);
		repeat (10) @(posedge clk);
		#1 check(cmd_ready, 1'b0);
		check(ready_pullup_en, 1'b1);
		xfer(chp_pkg::KIND_MEM_RD, 11'h123, 16'h0000);
		check(got.rdata, 16'hA123);
		xfer(chp_pkg::KIND_ATTR_RD, 11'h123, 16'h0000);
		check(got.rdata, 16'h5123);
	endtask

	// I/O mode: write then read back, acknowledge, info read
	task automatic sc_io();
		boot(1'b1, 1'b0);
		xfer(chp_pkg::KIND_IO_WR, 11'h010, 16'h1234);
		xfer(chp_pkg::KIND_IO_RD, 11'h010, 16'h0000);
		check(got.rdata, 16'h1224);
		check(got.acked, 1'b1);
		xfer(chp_pkg::KIND_IO_RD, 11'h410, 16'h0000);
		check({got.acked, got.rdata}, {1'b0, 16'h0000});
		xfer(chp_pkg::KIND_ATTR_RD, 11'h004, 16'h0000);
		check(got.rdata, 16'h5004);
		check(card_ack_request, 1'b1);
	endtask

	// disk mode: select pin, task file decode, two dma read words and one dma write word
	task automatic sc_disk();
		boot(1'b0, 1'b1);
		wait_hi(1'b0);
		check(card_oe_n, 1'b0);
		xfer(chp_pkg::KIND_IO_RD, 11'h7FD, 16'h0000);
		check(got.rdata, 16'hE005);
		@(posedge clk);
		dma_words <= 4'h2;
		dma_load <= 1'b1;
		dma_enable <= 1'b1;
		@(posedge clk);
		dma_load <= 1'b0;
		for (int n = 0; n < 2; n++) begin
			wait_hi(1'b1);
			check({rsp.from_dma, rsp.rdata}, {1'b1, 16'hD00D});
		end
		repeat (40) @(posedge clk);
		#1 check(dma_grant_n, 1'b1);
		// suspended write word: request stands, grant held off until resumed
		@(posedge clk);
		dma_suspend <= 1'b1;
		dma_dir_write <= 1'b1;
		dma_wdata <= 16'hBEEF;
		dma_words <= 4'h1;
		dma_load <= 1'b1;
		@(posedge clk);
		dma_load <= 1'b0;
		repeat (20) @(posedge clk);
		#1 check(dma_grant_n, 1'b1);
		@(posedge clk);
		dma_suspend <= 1'b0;
		wait_hi(1'b1);
		check(rsp.from_dma, 1'b1);
		xfer(chp_pkg::KIND_IO_RD, 11'h000, 16'h0000);
		check(got.rdata, 16'hBEEF);
	endtask

	initial begin
		sc_memory();
		sc_io();
		sc_disk();
		give_verdict();
	end
endmodule
